// ### common/lcas_pkg.sv
// constants for the lin capable async serial unit
package lcas_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLKSEL = 8'h08;
  localparam logic [7:0] ADDR_BAUD = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_TXBUF = 8'h14;
  localparam logic [7:0] ADDR_RXBUF = 8'h18;
  localparam logic [7:0] ADDR_ROUTE = 8'h1c;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_LEN8 = 2;
  localparam int ST_OVR = 0;
  localparam int ST_PAR = 1;
  localparam int ST_FRM = 2;
  localparam int ST_TXBUSY = 4;
  localparam int ST_TXFULL = 5;
  localparam int ST_RXFULL = 6;
  localparam int CTL_BRK_FLAG = 7;
  localparam int CTL_BRK_RXMODE = 6;
  localparam int CTL_BRK_TX = 5;
  localparam int CTL_BLEN_HI = 4;
  localparam int CTL_BLEN_LO = 2;
  localparam int CTL_MSB_FIRST = 1;
  localparam int CTL_INVERT = 0;
  localparam int RT_IRQ = 0;
  localparam int RT_TIMER = 1;
  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] BUF_RST = 8'hff;
  localparam logic [4:0] BAUD_RST = 5'h1f;
  localparam logic [4:0] BRK_TX_BASE = 5'h0d;
  localparam logic [4:0] BRK_RX_MIN = 5'h0b;
  localparam logic [4:0] BRK_SAT = 5'h1f;
  localparam logic [3:0] LEN_SHORT = 4'h7;
  localparam logic [3:0] LEN_LONG = 4'h8;
  localparam logic [1:0] GAP_TICKS = 2'h2;
  localparam int MAX_KBPS = 625;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_GAP,
                            TX_BREAK} lcas_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP,
                            RX_BREAK} lcas_rx_t;
endpackage

// ### rtl/lcas_uart.sv
// lin capable async serial unit: tx/rx engines, registers, routing
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// RL1 - Bit rates up to 625 kbps are reachable from the base clock.
// RL2 - Characters are seven or eight bits, both directions.
// RL3 - Transmitter and receiver run independently, full duplex.
// RL4 - Bit order selectable: MSB first or LSB first.
// RL5 - Inversion affects only the transmit output; partner must accept it.
// RL6 - Hardware break low of 13 to 20 bits, length in ctrl bits 4:2.
// RL7 - Transmit-done pulse after each character and after each break.
// RL8 - Low of 11+ bits then stop in break mode: flag and rx pulse.
// RL9 - Shorter low is a break error: no pulse, stay in break mode.
// RL10 - Break reception: no errors, no buffer transfer, shifter holds FFH.
// RL11 - Clock stopped: registers and tx pin keep their values.
// RL12 - After clock resumes, software clears power and both enables.
// RL13 - Software sets power first, then transmit or receive enable.
// RL14 - Enables sync to base clock; wait two base clocks to re-enable.
// RL15 - First transmit data written one base clock after enabling.
// RL16 - Back-to-back characters get two extra base clocks of gap.
// RL17 - Software avoids back-to-back transmission in LIN use.
// RL18 - Software sends 80H as the LIN wakeup in eight-bit mode.
// RL19 - Receive pin routed internally to irq and timer inputs.
// RL20 - Software reprograms baud after sync, reinitialises after checksum.
// RL21 - Power clear resets unit asynchronously, tx pin driven high.
// RL22 - Clearing an enable synchronously resets that circuit.
// RL23 - Idle line high; one low start bit, one high stop bit.
module lcas_uart (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  output logic tx_done_irq,
  output logic rx_irq,
  output logic wake_edge_irq_input,
  output logic timer_capture_input
);
  import lcas_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] clk_mask(input logic [2:0] sel);
    clk_mask = 8'((9'h001 << sel) - 9'h001);
  endfunction

  function automatic logic [3:0] char_len(input logic len8);
    char_len = len8 ? LEN_LONG : LEN_SHORT;
  endfunction

  // ----------------------------------------------------------------
  // configuration registers (kept across power off)
  // ----------------------------------------------------------------
  logic [7:0] mode;
  logic [2:0] base_clock_select;
  logic [4:0] baud_divider_ctrl;
  logic [2:0] break_length_field;
  logic msb_first, tx_invert;
  logic [1:0] input_route_control;
  logic unit_power_enable, tx_enable_bit, rx_enable_bit, len8;
  logic unit_rst_b;
  logic wr_mode, wr_ctrl;

  assign wr_mode = reg_wr && reg_addr == ADDR_MODE;
  assign wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
  assign unit_power_enable = mode[MODE_POWER];
  assign tx_enable_bit = mode[MODE_TXE];
  assign rx_enable_bit = mode[MODE_RXE];
  assign len8 = mode[MODE_LEN8];
  // power clear holds the whole engine in asynchronous reset
  assign unit_rst_b = rst_b & unit_power_enable; // RL21

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= MODE_RST;
      base_clock_select <= '0;
      baud_divider_ctrl <= BAUD_RST;
      break_length_field <= '0;
      msb_first <= 1'b0;
      tx_invert <= 1'b0;
      input_route_control <= '0;
    end else if (reg_wr) begin
      if (wr_mode)
        mode <= reg_wdata[7:0];
      if (reg_addr == ADDR_CLKSEL)
        base_clock_select <= reg_wdata[2:0];
      if (reg_addr == ADDR_BAUD)
        baud_divider_ctrl <= reg_wdata[4:0];
      if (wr_ctrl) begin
        break_length_field <= reg_wdata[CTL_BLEN_HI:CTL_BLEN_LO]; // RL6
        msb_first <= reg_wdata[CTL_MSB_FIRST]; // RL4
        tx_invert <= reg_wdata[CTL_INVERT];
      end
      if (reg_addr == ADDR_ROUTE)
        input_route_control <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // base clock tick and enable sync
  // ----------------------------------------------------------------
  // every slower rate is a tick; a stopped ref_clk freezes all state
  logic [7:0] div_cnt;
  logic base_tick, tx_en_s, rx_en_s;
  logic [5:0] bit_len, half_len;
  assign bit_len = {baud_divider_ctrl, 1'b0}; // RL1
  assign half_len = {1'b0, baud_divider_ctrl};

  always_ff @(posedge ref_clk or negedge unit_rst_b) begin // RL11
    if (!unit_rst_b) begin
      div_cnt <= '0;
      base_tick <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      base_tick <= (div_cnt & clk_mask(base_clock_select)) ==
                   clk_mask(base_clock_select);
    end
  end

  always_ff @(posedge ref_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      tx_en_s <= 1'b0;
      rx_en_s <= 1'b0;
    end else if (base_tick) begin
      tx_en_s <= tx_enable_bit; // RL14
      rx_en_s <= rx_enable_bit; // RL14
    end
  end

  // ----------------------------------------------------------------
  // receive pin synchroniser and routing
  // ----------------------------------------------------------------
  logic rx_m, rx_s;
  always_ff @(posedge ref_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
      wake_edge_irq_input <= 1'b1;
      timer_capture_input <= 1'b1;
    end else begin
      rx_m <= serial_rx_pin;
      rx_s <= rx_m;
      wake_edge_irq_input <= input_route_control[RT_IRQ] ? rx_s : 1'b1; // RL19
      timer_capture_input <= input_route_control[RT_TIMER] ? rx_s
                                                            : 1'b1; // RL19
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  lcas_tx_t tx_state;
  logic [7:0] tx_holding_buffer, tx_shift;
  logic [5:0] tx_bcnt;
  logic [4:0] tx_bits;
  logic [1:0] gap_cnt;
  logic tx_full, brk_req, tx_line, tx_bit_end;
  logic wr_txbuf, wr_brk;
  assign wr_txbuf = reg_wr && reg_addr == ADDR_TXBUF;
  assign wr_brk = wr_ctrl && reg_wdata[CTL_BRK_TX];
  assign tx_bit_end = base_tick && tx_bcnt == bit_len - 6'h01;

  always_ff @(posedge ref_clk or negedge unit_rst_b) begin
    if (!unit_rst_b)
      tx_holding_buffer <= BUF_RST;
    else if (wr_txbuf)
      tx_holding_buffer <= reg_wdata[7:0];
  end

  always_ff @(posedge ref_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      tx_state <= TX_IDLE;
      tx_shift <= BUF_RST;
      tx_bcnt <= '0;
      tx_bits <= '0;
      gap_cnt <= '0;
      tx_full <= 1'b0;
      brk_req <= 1'b0;
      tx_line <= 1'b1;
      tx_done_irq <= 1'b0;
    end else if (!tx_en_s) begin
      tx_state <= TX_IDLE; // RL22
      tx_full <= 1'b0;
      brk_req <= 1'b0;
      tx_line <= 1'b1;
      tx_done_irq <= 1'b0;
    end else begin
      tx_done_irq <= 1'b0;
      if (wr_txbuf)
        tx_full <= 1'b1;
      if (wr_brk)
        brk_req <= 1'b1;
      if (base_tick)
        tx_bcnt <= tx_bit_end ? 6'h00 : tx_bcnt + 6'h01;
      case (tx_state)
        TX_IDLE: begin
          tx_line <= 1'b1; // RL23
          tx_bcnt <= '0;
          if (brk_req) begin
            brk_req <= 1'b0;
            tx_bits <= BRK_TX_BASE + {2'b00, break_length_field}; // RL6
            tx_line <= 1'b0;
            tx_state <= TX_BREAK;
          end else if (tx_full) begin
            tx_full <= wr_txbuf;
            tx_shift <= tx_holding_buffer;
            tx_bits <= {1'b0, char_len(len8)}; // RL2
            tx_line <= 1'b0; // RL23
            tx_state <= TX_START;
          end
        end
        TX_START, TX_DATA: if (tx_bit_end) begin
          if (tx_bits == 5'h00) begin
            tx_line <= 1'b1; // RL23
            tx_state <= TX_STOP;
          end else begin
            tx_line <= msb_first ? tx_shift[7] : tx_shift[0]; // RL4
            tx_shift <= msb_first ? {tx_shift[6:0], 1'b1}
                                  : {1'b1, tx_shift[7:1]};
            tx_bits <= tx_bits - 5'h01;
            tx_state <= TX_DATA;
          end
        end
        TX_STOP: if (tx_bit_end) begin
          tx_done_irq <= 1'b1; // RL7
          gap_cnt <= '0;
          tx_state <= tx_full ? TX_GAP : TX_IDLE;
        end
        TX_GAP: if (base_tick) begin
          // back-to-back frames get two extra base clocks before start
          gap_cnt <= gap_cnt + 2'h1; // RL16
          if (gap_cnt == GAP_TICKS - 2'h1) begin
            // start straight from the gap: an idle cycle would add a third
            tx_full <= wr_txbuf;
            tx_shift <= tx_holding_buffer;
            tx_bits <= {1'b0, char_len(len8)}; // RL2
            tx_bcnt <= '0;
            tx_line <= 1'b0; // RL23
            tx_state <= TX_START;
          end
        end
        TX_BREAK: if (tx_bit_end) begin
          tx_bits <= tx_bits - 5'h01;
          if (tx_bits == 5'h01) begin
            tx_line <= 1'b1;
            tx_done_irq <= 1'b1; // RL7
            tx_state <= TX_IDLE;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // inversion touches only the pin driver, never the receive side
  always_ff @(posedge ref_clk or negedge unit_rst_b) begin
    if (!unit_rst_b)
      serial_tx_pin <= 1'b1; // RL21
    else
      serial_tx_pin <= tx_line ^ tx_invert; // RL5
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  lcas_rx_t rx_state; // RL3
  logic [7:0] rx_shift, rx_holding_buffer;
  logic [5:0] rx_bcnt;
  logic [4:0] rx_bits, low_bits;
  logic rx_full, ovr, frm, brk_flag, brk_mode, rx_smp, rx_half;
  logic rd_rxbuf, wr_st;
  assign rd_rxbuf = reg_rd && reg_addr == ADDR_RXBUF;
  assign wr_st = reg_wr && reg_addr == ADDR_STATUS;
  assign rx_smp = base_tick && rx_bcnt == bit_len - 6'h01;
  assign rx_half = base_tick && rx_bcnt == half_len - 6'h01;

  always_ff @(posedge ref_clk or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      rx_state <= RX_IDLE;
      rx_shift <= BUF_RST;
      rx_holding_buffer <= BUF_RST;
      rx_bcnt <= '0;
      rx_bits <= '0;
      low_bits <= '0;
      rx_full <= 1'b0;
      ovr <= 1'b0;
      frm <= 1'b0;
      brk_flag <= 1'b0;
      brk_mode <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= 1'b0;
      // a hardware set in the same cycle wins over the software clear
      if (rd_rxbuf)
        rx_full <= 1'b0;
      if (wr_st && reg_wdata[ST_OVR])
        ovr <= 1'b0;
      if (wr_st && reg_wdata[ST_FRM])
        frm <= 1'b0;
      if (wr_ctrl) begin
        brk_mode <= reg_wdata[CTL_BRK_RXMODE];
        if (!reg_wdata[CTL_BRK_FLAG])
          brk_flag <= 1'b0;
      end
      if (base_tick)
        rx_bcnt <= (rx_smp || rx_state == RX_IDLE) ? 6'h00
                                                   : rx_bcnt + 6'h01;
      if (!rx_en_s) begin
        rx_state <= RX_IDLE; // RL22
        rx_shift <= BUF_RST;
      end else case (rx_state)
        RX_IDLE: if (base_tick && !rx_s)
          rx_state <= RX_START;
        RX_START: if (rx_half) begin
          rx_bcnt <= '0;
          rx_bits <= {1'b0, char_len(len8)}; // RL2
          low_bits <= 5'h01;
          if (rx_s)
            rx_state <= RX_IDLE;
          else
            rx_state <= brk_mode ? RX_BREAK : RX_DATA;
        end
        RX_DATA: if (rx_smp) begin
          rx_shift <= msb_first ? {rx_shift[6:0], rx_s}
                                : {rx_s, rx_shift[7:1]}; // RL4
          rx_bits <= rx_bits - 5'h01;
          if (rx_bits == 5'h01)
            rx_state <= RX_STOP;
        end
        RX_STOP: if (rx_smp) begin
          rx_irq <= 1'b1;
          if (!rx_s)
            frm <= 1'b1;
          if (rx_full)
            ovr <= 1'b1;
          else begin
            rx_full <= 1'b1;
            // seven-bit data sits low for lsb first, high for msb first
            if (len8)
              rx_holding_buffer <= rx_shift;
            else if (msb_first)
              rx_holding_buffer <= {rx_shift[6:0], 1'b0};
            else
              rx_holding_buffer <= {1'b0, rx_shift[7:1]};
          end
          rx_shift <= BUF_RST;
          rx_state <= RX_IDLE;
        end
        RX_BREAK: if (rx_smp) begin
          rx_shift <= BUF_RST; // RL10
          if (!rx_s) begin
            if (low_bits != BRK_SAT)
              low_bits <= low_bits + 5'h01;
          end else begin
            rx_state <= RX_IDLE;
            if (low_bits >= BRK_RX_MIN) begin // RL8 RL9
              brk_flag <= 1'b1; // RL8
              brk_mode <= 1'b0;
              rx_irq <= 1'b1; // RL8
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      reg_rdata <= '0;
    else if (reg_rd) begin
      case (reg_addr)
        ADDR_MODE: reg_rdata <= {24'h0, mode};
        ADDR_STATUS: reg_rdata <= {25'h0, rx_full, tx_full,
                                   tx_state != TX_IDLE, 1'b0, frm, 1'b0, ovr};
        ADDR_CLKSEL: reg_rdata <= {29'h0, base_clock_select};
        ADDR_BAUD: reg_rdata <= {27'h0, baud_divider_ctrl};
        ADDR_CTRL: reg_rdata <= {24'h0, brk_flag, brk_mode,
                                 tx_state == TX_BREAK, break_length_field,
                                 msb_first, tx_invert};
        ADDR_TXBUF: reg_rdata <= {24'h0, tx_holding_buffer};
        ADDR_RXBUF: reg_rdata <= {24'h0, rx_holding_buffer};
        ADDR_ROUTE: reg_rdata <= {30'h0, input_route_control};
        default: reg_rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!unit_rst_b);

  AST_IDLE_HIGH: assert property ( // RL23
    tx_state == TX_IDLE && $past(tx_state) == TX_IDLE |-> tx_line)
    else $error("tx line low while idle");
  AST_TX_DONE: assert property ( // RL7
    tx_done_irq |-> $past(tx_state) == TX_STOP ||
                    $past(tx_state) == TX_BREAK)
    else $error("tx done without stop or break end");
  AST_BRK_SHIFT: assert property ( // RL10
    rx_state == RX_BREAK |=> rx_shift == BUF_RST)
    else $error("shifter not FFH in break");
  AST_BRK_NOXFER: assert property ( // RL10
    $rose(rx_full) |-> $past(rx_state) == RX_STOP)
    else $error("buffer loaded outside stop bit");
  AST_BRK_FLAG: assert property ( // RL8
    $rose(brk_flag) |-> rx_irq && $past(low_bits) >= BRK_RX_MIN)
    else $error("break flag without long low");
  AST_BRK_SHORT: assert property ( // RL9
    rx_state == RX_BREAK && rx_smp && rx_s && low_bits < BRK_RX_MIN
    && !wr_ctrl |=> !rx_irq && brk_mode)
    else $error("short break not rejected");
  AST_GAP: assert property ( // RL16
    tx_state == TX_START && $past(tx_state) == TX_GAP |-> gap_cnt == GAP_TICKS)
    else $error("back-to-back gap wrong");
  AST_TX_EN: assert property ( // RL22
    !tx_en_s |=> tx_state == TX_IDLE && tx_line)
    else $error("tx not reset by enable clear");
  AST_PIN: assert property ( // RL5
    ##1 serial_tx_pin == ($past(tx_line) ^ $past(tx_invert)))
    else $error("tx pin inversion wrong");

  COV_CHAR: cover property (tx_state == TX_STOP ##1 tx_done_irq);
  COV_BRK_RX: cover property ($rose(brk_flag));
  COV_BRK_TX: cover property (tx_state == TX_BREAK ##1 tx_done_irq);
  COV_RX: cover property ($rose(rx_full));
endmodule

// ### verification/lcas_remote_node.sv
// remote serial node model: frames onto the receive pin, decodes tx pin
`timescale 1ns/1ps
module lcas_remote_node #(
  parameter int BIT_CLKS = 16
) (
  input wire logic ref_clk,
  input wire logic line_in,
  input wire logic inv,
  output logic line_out
);
  // ----------------------------------------------------------------
  // drive side: idle high, as the bus pull-up would leave it
  // ----------------------------------------------------------------
  initial line_out = 1'b1;

  task automatic send(input logic [7:0] v, input int n);
    for (int i = -1; i <= n; i++) begin
      @(posedge ref_clk);
      line_out <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : v[i];
      repeat (BIT_CLKS - 1) @(posedge ref_clk);
    end
  endtask

  // low for whole bit times, then one high bit
  task automatic hold_low(input int n);
    @(posedge ref_clk);
    line_out <= 1'b0;
    repeat (n * BIT_CLKS) @(posedge ref_clk);
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // receive side: accepts inverted data when told to
  // ----------------------------------------------------------------
  task automatic capture(input int n, output logic [7:0] v,
                         output logic stop);
    v = 8'h00;
    @(posedge ref_clk);
    while ((line_in ^ inv) !== 1'b0) @(posedge ref_clk);
    repeat (BIT_CLKS / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CLKS) @(posedge ref_clk);
      v[i] = line_in ^ inv;
    end
    repeat (BIT_CLKS) @(posedge ref_clk);
    stop = line_in ^ inv;
  endtask
endmodule

// ### verification/lcas_uart_tb.sv
// self-checking bench for the lin capable async serial unit
`timescale 1ns/1ps
module lcas_uart_tb;
  import lcas_pkg::*;
  // base tick every clock, divider 8: 16 clocks a bit
  localparam int BIT = 16;
  typedef struct packed {
    logic len8;
    logic [7:0] ctrl;
    logic [7:0] data;
    logic [7:0] line_bits;
    logic [7:0] rx_exp;
  } lcas_row_t;
  // line_bits: bits in order of arrival on the wire
  localparam lcas_row_t ROWS [5] = '{
    '{1'b1, 8'h00, 8'h13, 8'h13, 8'h13},
    '{1'b1, 8'h02, 8'h13, 8'hc8, 8'h13},
    '{1'b0, 8'h00, 8'h13, 8'h13, 8'h13},
    '{1'b0, 8'h02, 8'h13, 8'h48, 8'h12},
    '{1'b1, 8'h01, 8'h80, 8'h80, 8'h80}};
  logic ref_clk;
  logic rst_b;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic rx_line;
  logic tx_line;
  logic tx_done_irq;
  logic rx_irq;
  logic wake;
  logic timer;
  logic inv;
  int errors = 0;
  int n_compared = 0;
  int n_txd = 0;
  int n_rxd = 0;
  int cycles = 0;

  lcas_uart lcas_uart_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_rx_pin(rx_line),
    .serial_tx_pin(tx_line), .tx_done_irq(tx_done_irq), .rx_irq(rx_irq),
    .wake_edge_irq_input(wake), .timer_capture_input(timer));
  lcas_remote_node #(.BIT_CLKS(BIT)) lcas_remote_node_i (
    .ref_clk(ref_clk), .line_in(tx_line), .inv(inv), .line_out(rx_line));

  // ----------------------------------------------------------------
  // clock, pulse counters, hang guard
  // ----------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (tx_done_irq === 1'b1) n_txd++;
    if (rx_irq === 1'b1) n_rxd++;
    cycles++;
    if (cycles == 10000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask

  // length of the next run of tx_line at level lvl, in clocks
  task automatic run_len(input logic lvl, output int cnt);
    cnt = 0;
    for (int w = 0; w < 1000 && tx_line !== lvl; w++) @(posedge ref_clk);
    while (tx_line === lvl) begin
      cnt++;
      @(posedge ref_clk);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int c;
    int n;
    int b_tx;
    int b_rx;
    logic [7:0] got;
    logic stop;
    ref_clk = 1'b0;
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    inv = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    chk("tx idle", 32'h1, {31'h0, tx_line});
    rchk("rx buffer", ADDR_RXBUF, 32'hff);
    rchk("unmapped", 8'h20, 32'h0);
    wr(ADDR_CLKSEL, 32'h0);
    wr(ADDR_BAUD, 32'h8);
    wr(ADDR_MODE, 32'h80);
    wr(ADDR_MODE, 32'he4);
    repeat (4) @(posedge ref_clk);
    foreach (ROWS[r]) begin
      wr(ADDR_MODE, {24'h0, 5'b11100, ROWS[r].len8, 2'b00});
      wr(ADDR_CTRL, {24'h0, ROWS[r].ctrl});
      inv <= ROWS[r].ctrl[CTL_INVERT];
      repeat (3) @(posedge ref_clk);
      n = ROWS[r].len8 ? 8 : 7;
      b_tx = n_txd;
      b_rx = n_rxd;
      // both directions at once
      fork
        lcas_remote_node_i.capture(n, got, stop);
        lcas_remote_node_i.send(ROWS[r].line_bits, n);
        wr(ADDR_TXBUF, {24'h0, ROWS[r].data});
      join
      repeat (2 * BIT) @(posedge ref_clk);
      chk("line bits", {24'h0, ROWS[r].line_bits}, 32'(got));
      chk("stop bit", 32'h1, {31'h0, stop});
      rchk("rx data", ADDR_RXBUF, {24'h0, ROWS[r].rx_exp});
      chk("tx done", b_tx + 1, n_txd);
      chk("rx irq", b_rx + 1, n_rxd);
    end
    // back-to-back characters: stop plus two extra base ticks
    wr(ADDR_CTRL, 32'h0);
    inv <= 1'b0;
    b_tx = n_txd;
    wr(ADDR_TXBUF, 32'h0);
    wr(ADDR_TXBUF, 32'h0);
    run_len(1'b0, c);
    run_len(1'b1, c);
    chk("stop gap", BIT + int'(GAP_TICKS), c);
    repeat (12 * BIT) @(posedge ref_clk);
    chk("b2b done", b_tx + 2, n_txd);
    // break transmit, shortest and longest setting
    for (int k = 0; k < 8; k += 7) begin
      b_tx = n_txd;
      wr(ADDR_CTRL, 32'h20 | (k << 2));
      run_len(1'b0, c);
      chk("break low", (13 + k) * BIT, c);
      repeat (4) @(posedge ref_clk);
      chk("break done", b_tx + 1, n_txd);
    end
    // break receive: short low refused, long low accepted
    wr(ADDR_ROUTE, 32'h3);
    wr(ADDR_CTRL, 32'h40);
    b_rx = n_rxd;
    lcas_remote_node_i.hold_low(10);
    repeat (BIT) @(posedge ref_clk);
    chk("short break", b_rx, n_rxd);
    rchk("still break mode", ADDR_CTRL, 32'h40);
    fork
      lcas_remote_node_i.hold_low(11);
      begin
        repeat (5 * BIT) @(posedge ref_clk);
        chk("irq route", 32'h0, {31'h0, wake});
        chk("timer route", 32'h0, {31'h0, timer});
      end
    join
    repeat (BIT) @(posedge ref_clk);
    chk("break irq", b_rx + 1, n_rxd);
    rchk("break flag", ADDR_CTRL, 32'h80);
    rchk("no transfer", ADDR_RXBUF, 32'h80);
    rchk("no errors", ADDR_STATUS, 32'h0);
    // sync field done: clear both enables, reload the divider, restart
    wr(ADDR_MODE, 32'h84);
    wr(ADDR_BAUD, 32'h8);
    wr(ADDR_MODE, 32'he4);
    rchk("baud reload", ADDR_BAUD, 32'h8);
    wr(ADDR_ROUTE, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk("route off", 32'h1, {31'h0, wake});
    // transmit disable mid-frame, then power off mid-frame
    wr(ADDR_TXBUF, 32'h0);
    repeat (3 * BIT) @(posedge ref_clk);
    wr(ADDR_MODE, 32'ha4);
    repeat (4) @(posedge ref_clk);
    chk("tx disabled", 32'h1, {31'h0, tx_line});
    rchk("tx idle status", ADDR_STATUS, 32'h0);
    wr(ADDR_MODE, 32'he4);
    repeat (4) @(posedge ref_clk);
    wr(ADDR_TXBUF, 32'h0);
    repeat (3 * BIT) @(posedge ref_clk);
    wr(ADDR_MODE, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("tx power off", 32'h1, {31'h0, tx_line});
    rchk("rx buffer off", ADDR_RXBUF, 32'hff);
    rchk("flags off", ADDR_CTRL, 32'h0);
    rchk("status off", ADDR_STATUS, 32'h0);
    test_done();
  end
endmodule
